/* File: rtl/logic_and_bit_ops_exec.sv */
/*
 executes file AND, literal AND, bit clear and bit set in one cycle.
 assumes instrValid pulses once per instruction cycle on ref_clk; the port
 pins come from outside and are synchronised here.
*/
module logic_and_bit_ops_exec
  import logic_bit_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  input  wire logic               instrValid,
  input  wire logic [INSTR_W-1:0] instrWord,
  input  wire logic [DATA_W-1:0]  portPins,
  input  wire logic               prescalerToTimer,
  output logic [DATA_W-1:0]       workReg,
  output logic                    zeroFlag,
  output logic                    prescalerClear,
  output logic [DATA_W-1:0]       portLatch,
  output logic [DATA_W-1:0]       timerCount
);
  op_t                 opKind;
  logic [ADDR_W-1:0]   fileAddr;
  logic [BSEL_W-1:0]   bitSel;
  logic                destFile;
  logic [DATA_W-1:0]   literal;
  logic [DATA_W-1:0]   fileMem_ff [FILE_CNT];
  logic [DATA_W-1:0]   work_ff;
  logic                zero_ff;
  logic                presClr_ff;
  logic [DATA_W-1:0]   pinS1_ff;
  logic [DATA_W-1:0]   pinS2_ff;
  logic [DATA_W-1:0]   pinS3_ff;
  logic [DATA_W-1:0]   pinLevel_ff;
  logic [DATA_W-1:0]   srcVal;
  logic [DATA_W-1:0]   nxt_result;
  logic                writeFile;
  logic                writeWork;
  logic                portRead;
  logic                timerHit;
  logic                andOp;
  logic                fileWrEn;
  logic                workWrEn;
  logic [DATA_W-1:0]   bitMask;

  // ************
  // instruction decoder
  // ************
  instr_decode u_decode (
    .instrWord (instrWord),
    .opKind    (opKind),
    .fileAddr  (fileAddr),
    .bitSel    (bitSel),
    .destFile  (destFile),
    .literal   (literal)
  );

  // ************
  // pin synchroniser
  // ************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinS1_ff <= DATA_RESET;
    end else begin
      pinS1_ff <= portPins;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinS2_ff <= DATA_RESET;
    end else begin
      pinS2_ff <= pinS1_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinS3_ff <= DATA_RESET;
    end else begin
      pinS3_ff <= pinS2_ff;
    end
  end

  // a pin change counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinLevel_ff <= DATA_RESET;
    end else if (pinS2_ff == pinS3_ff) begin
      pinLevel_ff <= pinS3_ff;
    end
  end

  // ************
  // operand select
  // ************
  always_comb begin
    portRead = (fileAddr == PORT_ADDR);
    if (portRead) begin
      srcVal = pinLevel_ff;
    end else begin
      srcVal = fileMem_ff[fileAddr];
    end
  end

  assign timerHit = (fileAddr == TIMER_ADDR);

  // ************
  // bit select mask
  // ************
  generate
    for (genvar j = 0; j < DATA_W; j++) begin : g_mask
      assign bitMask[j] = (bitSel == BSEL_W'(j));
    end
  endgenerate

  // ************
  // result
  // ************
  always_comb begin
    nxt_result = DATA_RESET;
    case (opKind)
      OP_AND_FILE: begin
        nxt_result = work_ff & srcVal;
      end
      OP_AND_LIT: begin
        nxt_result = work_ff & literal;
      end
      OP_BIT_CLR: begin
        nxt_result = srcVal & ~bitMask;
      end
      OP_BIT_SET: begin
        nxt_result = srcVal | bitMask;
      end
      default: begin
        nxt_result = DATA_RESET;
      end
    endcase
  end

  // ************
  // write enables
  // ************
  always_comb begin
    writeFile = 1'b0;
    writeWork = 1'b0;
    case (opKind)
      OP_AND_FILE: begin
        writeFile = destFile;
        writeWork = !destFile;
      end
      OP_AND_LIT: begin
        writeWork = 1'b1;
      end
      OP_BIT_CLR: begin
        writeFile = 1'b1;
      end
      OP_BIT_SET: begin
        writeFile = 1'b1;
      end
      default: begin
        writeFile = 1'b0;
        writeWork = 1'b0;
      end
    endcase
  end

  assign andOp    = (opKind == OP_AND_FILE) || (opKind == OP_AND_LIT);
  assign fileWrEn = instrValid && writeFile;
  assign workWrEn = instrValid && writeWork;

  // ************
  // file registers
  // ************
  generate
    for (genvar i = 0; i < FILE_CNT; i++) begin : g_file
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          fileMem_ff[i] <= DATA_RESET;
        end else if (fileWrEn && fileAddr == ADDR_W'(i)) begin
          fileMem_ff[i] <= nxt_result;
        end
      end
    end
  endgenerate

  // ************
  // work register
  // ************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      work_ff <= DATA_RESET;
    end else if (workWrEn) begin
      work_ff <= nxt_result;
    end
  end

  // ************
  // zero flag
  // ************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      zero_ff <= 1'b0;
    end else if (instrValid && andOp) begin
      zero_ff <= (nxt_result == DATA_RESET);
    end
  end

  // ************
  // prescaler clear
  // ************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      presClr_ff <= 1'b0;
    end else begin
      presClr_ff <= fileWrEn && timerHit && prescalerToTimer;
    end
  end

  // ************
  // outputs
  // ************
  assign workReg        = work_ff;
  assign zeroFlag       = zero_ff;
  assign prescalerClear = presClr_ff;
  assign portLatch      = fileMem_ff[PORT_ADDR];
  assign timerCount     = fileMem_ff[TIMER_ADDR];
endmodule : logic_and_bit_ops_exec

/* File: rtl/logic_bit_pkg.sv */
/*
 constants for the logic and bit-operation execution block.
 assumes one core clock and an 8-bit data path with 32 file registers.
*/
// Function
// - file AND: work register AND addressed file
// - destination bit picks work or file
// - literal AND with instruction low byte
// - literal AND writes work register only
// - bit clear zeroes selected bit only
// - bit set ones selected bit only
// - port self-modify reads pin levels
// - timer write clears assigned prescaler
package logic_bit_pkg;
  localparam int DATA_W   = 8;
  localparam int INSTR_W  = 12;
  localparam int ADDR_W   = 5;
  localparam int FILE_CNT = 32;
  localparam int BSEL_W   = 3;
  // opcode patterns and masks
  localparam logic [11:0] AND_FILE_MASK = 12'hfc0;
  localparam logic [11:0] AND_FILE_PAT  = 12'h140;
  localparam logic [11:0] AND_LIT_MASK  = 12'hf00;
  localparam logic [11:0] AND_LIT_PAT   = 12'he00;
  localparam logic [11:0] BIT_OP_MASK   = 12'hf00;
  localparam logic [11:0] BIT_CLR_PAT   = 12'h400;
  localparam logic [11:0] BIT_SET_PAT   = 12'h500;
  // instruction fields
  localparam int DEST_BIT = 5;
  localparam int BSEL_LSB = 5;
  // special register addresses
  localparam logic [4:0] TIMER_ADDR = 5'h01;
  localparam logic [4:0] PORT_ADDR  = 5'h06;
  localparam logic [7:0] DATA_RESET = 8'h00;
  typedef enum logic [2:0] {OP_NONE, OP_AND_FILE, OP_AND_LIT, OP_BIT_CLR, OP_BIT_SET} op_t;
endpackage : logic_bit_pkg

/* File: rtl/instr_decode.sv */
/*
 decodes a 12-bit instruction word into an operation and fields.
 assumes the word is stable in the cycle it is presented.
*/
module instr_decode
  import logic_bit_pkg::*;
(
  input  wire logic [INSTR_W-1:0] instrWord,
  output op_t                     opKind,
  output logic [ADDR_W-1:0]       fileAddr,
  output logic [BSEL_W-1:0]       bitSel,
  output logic                    destFile,
  output logic [DATA_W-1:0]       literal
);
  assign fileAddr = instrWord[ADDR_W-1:0];
  assign bitSel   = instrWord[BSEL_LSB +: BSEL_W];
  assign destFile = instrWord[DEST_BIT];
  assign literal  = instrWord[DATA_W-1:0];
  always_comb begin
    if ((instrWord & AND_FILE_MASK) == AND_FILE_PAT) begin
      opKind = OP_AND_FILE;
    end else if ((instrWord & AND_LIT_MASK) == AND_LIT_PAT) begin
      opKind = OP_AND_LIT;
    end else if ((instrWord & BIT_OP_MASK) == BIT_CLR_PAT) begin
      opKind = OP_BIT_CLR;
    end else if ((instrWord & BIT_OP_MASK) == BIT_SET_PAT) begin
      opKind = OP_BIT_SET;
    end else begin
      opKind = OP_NONE;
    end
  end
endmodule : instr_decode

/* File: verification/logic_bit_asserts.sv */
/* checker for the logic and bit-operation block.
 sees only top ports; bound after endmodule */
module logic_bit_asserts
  import logic_bit_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               reset_n,
  input wire logic               instrValid,
  input wire logic [INSTR_W-1:0] instrWord,
  input wire logic               prescalerToTimer,
  input wire logic [DATA_W-1:0]  workReg,
  input wire logic               zeroFlag,
  input wire logic               prescalerClear,
  input wire logic [DATA_W-1:0]  timerCount
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic litOp, bitOp, andT, tmrHit, bitT;
  assign litOp  = instrValid && (instrWord & AND_LIT_MASK) == AND_LIT_PAT;
  assign bitOp  = instrValid && instrWord[11:9] == 3'b010;
  assign bitT   = bitOp && instrWord[4:0] == TIMER_ADDR;
  assign andT   = instrValid && (instrWord & AND_FILE_MASK) == AND_FILE_PAT && instrWord[4:0] == TIMER_ADDR;
  assign tmrHit = prescalerToTimer && (bitT || andT && instrWord[5]);
  lit_and_a: assert property (litOp |=> workReg == ($past(workReg) & $past(instrWord[7:0])))
    else $error("literal and result wrong");
  lit_file_a: assert property (litOp |=> $stable(timerCount)) else $error("literal and touched file");
  and_zero_a: assert property (litOp |=> zeroFlag == (workReg == 8'h00)) else $error("zero flag wrong");
  andf_work_a: assert property (andT && !instrWord[5] |=> workReg == ($past(workReg) & $past(timerCount))
    && $stable(timerCount)) else $error("file and to work wrong");
  andf_file_a: assert property (andT && instrWord[5] |=> timerCount == ($past(workReg) & $past(timerCount))
    && $stable(workReg)) else $error("file and to file wrong");
  bit_set_a: assert property (bitT && instrWord[8] |=>
    timerCount == ($past(timerCount) | (8'h01 << $past(instrWord[7:5])))) else $error("bit set wrong");
  bit_clr_a: assert property (bitT && !instrWord[8] |=>
    timerCount == ($past(timerCount) & ~(8'h01 << $past(instrWord[7:5])))) else $error("bit clear wrong");
  bit_flags_a: assert property (bitOp |=> $stable(zeroFlag) && $stable(workReg))
    else $error("bit op changed flags");
  presc_clr_a: assert property (tmrHit |=> prescalerClear) else $error("prescaler not cleared");
  presc_only_a: assert property (prescalerClear |-> $past(tmrHit)) else $error("stray prescaler clear");
endmodule : logic_bit_asserts
bind logic_and_bit_ops_exec logic_bit_asserts chk (.ref_clk(ref_clk), .reset_n(reset_n), .instrValid(instrValid),
  .instrWord(instrWord), .prescalerToTimer(prescalerToTimer), .workReg(workReg), .zeroFlag(zeroFlag),
  .prescalerClear(prescalerClear), .timerCount(timerCount));

/* File: verification/logic_and_bit_ops_exec_tb.sv */
/* bench for the logic and bit-operation block.
 drives every input itself; no partner model */
module logic_and_bit_ops_exec_tb
  import logic_bit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              ref_clk = 0, reset_n = 0, instrValid = 0, prescalerToTimer = 0, zeroFlag, prescalerClear;
  logic              zm = 0, pc = 0;
  logic [INSTR_W-1:0] instrWord = '0, w;
  logic [DATA_W-1:0]  portPins = '0, workReg, portLatch, timerCount, tm = 0, pm = 0, wm = 0, pv = 0;
  int                err_count = 0, n_compared = 0, k;
  always #2.5 ref_clk = ~ref_clk;
  logic_and_bit_ops_exec dut (.ref_clk(ref_clk), .reset_n(reset_n), .instrValid(instrValid), .instrWord(instrWord),
    .portPins(portPins), .prescalerToTimer(prescalerToTimer), .workReg(workReg), .zeroFlag(zeroFlag),
    .prescalerClear(prescalerClear), .portLatch(portLatch), .timerCount(timerCount));
  task chk(string nm, logic [7:0] e, logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // expected result of one instruction from operand f and work value wv
  function automatic logic [7:0] fnew(logic [7:0] f, logic [7:0] wv, logic [11:0] c);
    if (c[11:8] == 4'h4) return f & ~(8'h01 << c[7:5]);
    if (c[11:8] == 4'h5) return f | (8'h01 << c[7:5]);
    if (c[11:8] == 4'he) return wv & c[7:0];
    return wv & f;
  endfunction : fnew
  task op(logic [11:0] c, logic v);
    logic p;
    logic wr;
    logic [7:0] r;
    p = 1'($urandom);
    wr = v && (c[11:9] == 3'b010 || c[11:5] == 7'h0b);
    @(posedge ref_clk);
    instrValid <= v;
    instrWord <= c;
    prescalerToTimer <= p;
    portPins <= pv;
    @(negedge ref_clk);
    chk("work", wm, workReg);
    chk("zero", {7'h00, zm}, {7'h00, zeroFlag});
    chk("timer", tm, timerCount);
    chk("port", pm, portLatch);
    chk("presc", {7'h00, pc}, {7'h00, prescalerClear});
    pc = wr && p && c[4:0] == TIMER_ADDR;
    r = fnew((c[4:0] == PORT_ADDR) ? pv : tm, wm, c);
    if (wr && c[4:0] == TIMER_ADDR) tm = r;
    if (wr && c[4:0] == PORT_ADDR) pm = r;
    if (v && (c[11:8] == 4'he || c[11:6] == 6'h05)) zm = (r == 8'h00);
    if (v && (c[11:8] == 4'he || c[11:5] == 7'h0a)) wm = r;
  endtask : op
  task end_sim;
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  initial begin
    void'($urandom(58445));
    pv = 8'($urandom);
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    op(12'h541, 1'b1);
    op(12'h621, 1'b1);
    repeat (2) op(12'h000, 1'b0);
    repeat (400) begin
      k = $urandom % 4;
      w = 12'($urandom);
      w[4:0] = w[0] ? TIMER_ADDR : PORT_ADDR;
      case (k)
        0: w = {6'h05, w[5:0]};
        1: w = {4'he, w[7:0]};
        default: w = {3'b010, k[0], w[7:0]};
      endcase
      op(w, 1'b1);
    end
    pv = ~pv;
    repeat (8) op(12'h000, 1'b0);
    op(12'h5e6, 1'b1);
    op(12'h000, 1'b0);
    end_sim;
  end
  initial begin
    #10000;
    err_count++;
    end_sim;
  end
endmodule : logic_and_bit_ops_exec_tb
